// ---- verilog/wct_top.sv ----
`timescale 1ns/1ps
`default_nettype none
module wct_top #(
   parameter int BASE_DIV = wct_pkg::BASE_DIV_CYC,
   parameter int CNT_W = 8
) (
   // Clock and reset
   input wire logic sys_clk_i,
   input wire logic rst_i,
   // Register port
   input wire logic [7:0] reg_addr_i,
   input wire logic reg_wr_i,
   input wire logic reg_rd_i,
   input wire logic [7:0] reg_wdata_i,
   output logic [7:0] reg_rdata_o,
   // Companion flags and enables
   input wire logic minute_second_flag_i,
   input wire logic countdown_irq_enable_i,
   // Outputs to host
   output logic irq_n_o,
   output logic rst_n_o
);
   // ==========================================================
   // Timebase
   logic [3:0] tick;
   logic src_tick;

   wct_div #(.DIV(BASE_DIV)) u_div_base (
      .sys_clk_i(sys_clk_i), .rst_i(rst_i),
      .tick_i(1'b1), .tick_o(tick[0]));
   wct_div #(.DIV(wct_pkg::DIV_64HZ)) u_div_64 (
      .sys_clk_i(sys_clk_i), .rst_i(rst_i),
      .tick_i(tick[0]), .tick_o(tick[1]));
   wct_div #(.DIV(wct_pkg::DIV_1HZ)) u_div_1 (
      .sys_clk_i(sys_clk_i), .rst_i(rst_i),
      .tick_i(tick[1]), .tick_o(tick[2]));
   wct_div #(.DIV(wct_pkg::DIV_1MIN)) u_div_min (
      .sys_clk_i(sys_clk_i), .rst_i(rst_i),
      .tick_i(tick[2]), .tick_o(tick[3]));

   // ==========================================================
   // Registers
   wct_pkg::wct_mode_t timer_mode_select_r;
   logic irq_pulse_select_r;
   logic [1:0] source_clock_select_r;
   logic [CNT_W-1:0] timer_value_r;
   logic [CNT_W-1:0] cnt_r;
   logic [CNT_W-1:0] cnt_nxt;
   logic watchdog_expired_flag_r;
   logic countdown_expired_flag_r;
   logic wdf_nxt;
   logic cdf_nxt;
   logic irq_pulse_r;
   logic msf_q_r;

   // One mux picks the tick for both timers
   assign src_tick = tick[source_clock_select_r];

   // ==========================================================
   // Decode
   logic wr_ctl, wr_val, wr_st, rd_st;
   logic mode_wd, mode_cd, cnt_one, wd_expire, cd_expire;

   assign wr_ctl = reg_wr_i && (reg_addr_i == wct_pkg::ADDR_CTL);
   assign wr_val = reg_wr_i && (reg_addr_i == wct_pkg::ADDR_VAL);
   assign wr_st = reg_wr_i && (reg_addr_i == wct_pkg::ADDR_STATUS);
   assign rd_st = reg_rd_i && (reg_addr_i == wct_pkg::ADDR_STATUS);
   assign mode_wd = (timer_mode_select_r == wct_pkg::WCT_MODE_WD_IRQ) ||
                    (timer_mode_select_r == wct_pkg::WCT_MODE_WD_RST);
   assign mode_cd = (timer_mode_select_r == wct_pkg::WCT_MODE_CD);
   assign cnt_one = (cnt_r == CNT_W'(1));
   assign wd_expire = mode_wd && src_tick && cnt_one;
   assign cd_expire = mode_cd && src_tick && cnt_one;

   // ==========================================================
   // Counter
   // A value write replaces the running count at once; the tick
   // taken in the same cycle acts on the old count only.
   always_comb begin
      cnt_nxt = cnt_r;
      if (wr_val) begin
         cnt_nxt = CNT_W'(reg_wdata_i);
      end else if (wd_expire) begin
         cnt_nxt = '0;
      end else if (cd_expire) begin
         cnt_nxt = timer_value_r;
      end else if ((mode_wd || mode_cd) && src_tick && cnt_r != '0) begin
         cnt_nxt = cnt_r - CNT_W'(1);
      end
   end

   // ==========================================================
   // Flags: hardware set wins over any clear in the same cycle
   assign wdf_nxt = wd_expire ? 1'b1 :
                    ((wr_val || rd_st) ? 1'b0 :
                     watchdog_expired_flag_r);
   assign cdf_nxt = cd_expire ? 1'b1 :
                    ((wr_st && !reg_wdata_i[wct_pkg::ST_CDF_BIT]) ? 1'b0 :
                     countdown_expired_flag_r);

   // ==========================================================
   // Interrupt and reset sources
   logic cd_src, lvl_src, set_evt, irq_act, rst_act;

   // Pulse source fires on a new setting only, never on a held flag
   assign cd_src = countdown_expired_flag_r && countdown_irq_enable_i;
   assign lvl_src = minute_second_flag_i || cd_src;
   assign set_evt = (cd_expire && countdown_irq_enable_i) ||
                    (minute_second_flag_i && !msf_q_r);
   // Watchdog interrupt stays a level even in pulse style
   assign irq_act = (irq_pulse_select_r ? irq_pulse_r : lvl_src) ||
                    (watchdog_expired_flag_r &&
                     timer_mode_select_r == wct_pkg::WCT_MODE_WD_IRQ);
   assign rst_act = watchdog_expired_flag_r &&
                    (timer_mode_select_r == wct_pkg::WCT_MODE_WD_RST);

   // ==========================================================
   // Read data
   logic [7:0] ctl_rd, st_rd, rd_mux;

   assign ctl_rd = {timer_mode_select_r, irq_pulse_select_r, 3'h0,
                    source_clock_select_r};
   assign st_rd = {minute_second_flag_i, watchdog_expired_flag_r, 2'h0,
                   countdown_expired_flag_r, 3'h0};
   // Value reads return the live count, not the loaded n
   assign rd_mux = (reg_addr_i == wct_pkg::ADDR_CTL) ? ctl_rd :
                   (reg_addr_i == wct_pkg::ADDR_VAL) ? 8'(cnt_r) :
                   (reg_addr_i == wct_pkg::ADDR_STATUS) ? st_rd : 8'h00;

   // ==========================================================
   // Sequential state
   // Value register is never reset so it survives later resets.
   always_ff @(posedge sys_clk_i) begin
      if (wr_val) begin
         timer_value_r <= CNT_W'(reg_wdata_i);
      end
   end

   always_ff @(posedge sys_clk_i) begin
      if (rst_i) begin
         timer_mode_select_r <= wct_pkg::wct_mode_t'(wct_pkg::MODE_RST);
         irq_pulse_select_r <= wct_pkg::PULSE_RST;
         source_clock_select_r <= wct_pkg::SRC_RST;
      end else if (wr_ctl) begin
         timer_mode_select_r <= wct_pkg::wct_mode_t'(
            reg_wdata_i[wct_pkg::CTL_MODE_HI:wct_pkg::CTL_MODE_LO]);
         irq_pulse_select_r <= reg_wdata_i[wct_pkg::CTL_PULSE_BIT];
         source_clock_select_r <=
            reg_wdata_i[wct_pkg::CTL_SRC_HI:wct_pkg::CTL_SRC_LO];
      end
   end

   always_ff @(posedge sys_clk_i) begin
      if (rst_i) begin
         cnt_r <= '0;
         watchdog_expired_flag_r <= 1'b0;
         countdown_expired_flag_r <= 1'b0;
         msf_q_r <= 1'b0;
      end else begin
         cnt_r <= cnt_nxt;
         watchdog_expired_flag_r <= wdf_nxt;
         countdown_expired_flag_r <= cdf_nxt;
         msf_q_r <= minute_second_flag_i;
      end
   end

   // Pulse lasts until the next base tick, at most one 4.096 kHz period
   always_ff @(posedge sys_clk_i) begin
      if (rst_i) begin
         irq_pulse_r <= 1'b0;
      end else if (set_evt) begin
         irq_pulse_r <= 1'b1;
      end else if (tick[0]) begin
         irq_pulse_r <= 1'b0;
      end
   end

   always_ff @(posedge sys_clk_i) begin
      if (rst_i) begin
         irq_n_o <= 1'b1;
         rst_n_o <= 1'b1;
         reg_rdata_o <= 8'h00;
      end else begin
         irq_n_o <= !irq_act;
         rst_n_o <= !rst_act;
         if (reg_rd_i) begin
            reg_rdata_o <= rd_mux;
         end
      end
   end

   // ==========================================================
   // Assertions
   default clocking cb @(posedge sys_clk_i); endclocking
   default disable iff (rst_i);

   // A load that meets an expiring tick keeps the flag, so skip it
   sequence s_wd_load;
      mode_wd && wr_val && reg_wdata_i != 8'h00 && !wd_expire;
   endsequence
   sequence s_counts_from_n;
      ##1 (cnt_r == $past(reg_wdata_i) && !watchdog_expired_flag_r);
   endsequence

   property p_ctl_zero;
      reg_rd_i && reg_addr_i == wct_pkg::ADDR_CTL |=> reg_rdata_o[4:2] == 3'h0;
   endproperty
   a_ctl_zero: assert property (p_ctl_zero)
      else $error("control bits 4:2 not zero");

   property p_wd_expire;
      mode_wd && src_tick && cnt_r == 8'h01 && !wr_val
         |=> watchdog_expired_flag_r && cnt_r == 8'h00;
   endproperty
   a_wd_expire: assert property (p_wd_expire)
      else $error("watchdog did not expire at count 1");

   property p_no_reload;
      watchdog_expired_flag_r && cnt_r == 8'h00 && !wr_val |=> cnt_r == 8'h00;
   endproperty
   a_no_reload: assert property (p_no_reload)
      else $error("expired watchdog reloaded");

   property p_wd_reload;
      s_wd_load |-> s_counts_from_n;
   endproperty
   a_wd_reload: assert property (p_wd_reload)
      else $error("watchdog not restarted from new value");

   property p_service;
      mode_wd && wr_val && !wd_expire |=> !watchdog_expired_flag_r ##1
         (irq_n_o || $past(lvl_src || irq_pulse_r)) && rst_n_o;
   endproperty
   a_service: assert property (p_service)
      else $error("service write did not release outputs");

   property p_rst_out;
      timer_mode_select_r == wct_pkg::WCT_MODE_WD_RST &&
         watchdog_expired_flag_r |=> !rst_n_o;
   endproperty
   a_rst_out: assert property (p_rst_out)
      else $error("reset output not driven while expired");

   property p_zero_stop;
      wr_val && reg_wdata_i == 8'h00 && !wd_expire
         |=> (cnt_r == 8'h00 && !watchdog_expired_flag_r) ##1
             (cnt_r == 8'h00 || $past(wr_val)) ##1 rst_n_o;
   endproperty
   a_zero_stop: assert property (p_zero_stop)
      else $error("zero load did not stop watchdog");

   property p_st_read;
      rd_st && !wd_expire |=> !watchdog_expired_flag_r;
   endproperty
   a_st_read: assert property (p_st_read)
      else $error("status read did not clear watchdog flag");

   property p_cd_reload;
      cd_expire && !wr_val
         |=> cnt_r == timer_value_r && countdown_expired_flag_r;
   endproperty
   a_cd_reload: assert property (p_cd_reload)
      else $error("countdown did not reload and flag");

   property p_cd_level;
      !irq_pulse_select_r && countdown_irq_enable_i &&
         countdown_expired_flag_r |=> !irq_n_o;
   endproperty
   a_cd_level: assert property (p_cd_level)
      else $error("countdown level interrupt missing");

   property p_off_hold;
      timer_mode_select_r == wct_pkg::WCT_MODE_OFF && !wr_val
         |=> $stable(cnt_r);
   endproperty
   a_off_hold: assert property (p_off_hold)
      else $error("counter moved with timers off");

   property p_pulse_end;
      irq_pulse_select_r && irq_pulse_r && tick[0] && !set_evt
         |=> !irq_pulse_r;
   endproperty
   a_pulse_end: assert property (p_pulse_end)
      else $error("interrupt pulse not ended at base tick");
endmodule : wct_top
`default_nettype wire

// ---- verilog/wct_pkg.sv ----
package wct_pkg;
   // ==========================================================
   // Register map
   localparam logic [7:0] ADDR_STATUS = 8'h01;
   localparam logic [7:0] ADDR_CTL = 8'h10;
   localparam logic [7:0] ADDR_VAL = 8'h11;

   // ==========================================================
   // Control register fields
   localparam int CTL_MODE_HI = 7;
   localparam int CTL_MODE_LO = 6;
   localparam int CTL_PULSE_BIT = 5;
   localparam int CTL_SRC_HI = 1;
   localparam int CTL_SRC_LO = 0;
   localparam logic [1:0] MODE_RST = 2'h0;
   localparam logic PULSE_RST = 1'h0;
   localparam logic [1:0] SRC_RST = 2'h3;

   // ==========================================================
   // Status register fields
   localparam int ST_MSF_BIT = 7;
   localparam int ST_WDF_BIT = 6;
   localparam int ST_CDF_BIT = 3;

   // ==========================================================
   // Timer modes for the control mode field
   typedef enum logic [1:0] {
      WCT_MODE_OFF = 2'h0,
      WCT_MODE_CD = 2'h1,
      WCT_MODE_WD_IRQ = 2'h2,
      WCT_MODE_WD_RST = 2'h3
   } wct_mode_t;

   // ==========================================================
   // Timing: system clock and timebase rates
   localparam longint SYS_CLK_HZ = 250_000_000;
   localparam longint BASE_TICK_HZ = 4096;
   localparam int BASE_DIV_CYC = int'(SYS_CLK_HZ / BASE_TICK_HZ);
   localparam int DIV_64HZ = 64;
   localparam int DIV_1HZ = 64;
   localparam int DIV_1MIN = 60;
endpackage : wct_pkg

// ---- verilog/wct_div.sv ----
`timescale 1ns/1ps
`default_nettype none
module wct_div #(
   parameter int DIV = 64
) (
   // Clock and reset
   input wire logic sys_clk_i,
   input wire logic rst_i,
   // Tick chain
   input wire logic tick_i,
   output logic tick_o
);
   localparam int W = $clog2(DIV + 1);
   localparam logic [W-1:0] LAST = W'(DIV - 1);

   logic [W-1:0] cnt_r;
   logic [W-1:0] cnt_nxt;
   logic wrap;

   assign wrap = tick_i && (cnt_r == LAST);
   assign cnt_nxt = wrap ? '0 : (tick_i ? cnt_r + W'(1) : cnt_r);

   always_ff @(posedge sys_clk_i) begin
      if (rst_i) begin
         cnt_r <= '0;
         tick_o <= 1'b0;
      end else begin
         cnt_r <= cnt_nxt;
         tick_o <= wrap;
      end
   end
endmodule : wct_div
`default_nettype wire

// ---- dv/wct_host.sv ----
`timescale 1ns/1ps
`default_nettype none
module wct_host (
   // Clock
   input wire logic sys_clk_i,
   // Register port
   output logic [7:0] reg_addr_o,
   output logic reg_wr_o,
   output logic reg_rd_o,
   output logic [7:0] reg_wdata_o,
   input wire logic [7:0] reg_rdata_i
);
   initial begin
      reg_addr_o = 8'h00;
      reg_wr_o = 1'b0;
      reg_rd_o = 1'b0;
      reg_wdata_o = 8'h00;
   end

   // ==========================================
   // Bus cycles
   // Released lines show the inverse, so stale values never pass
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge sys_clk_i);
      reg_addr_o <= a;
      reg_wdata_o <= d;
      reg_wr_o <= 1'b1;
      @(posedge sys_clk_i);
      reg_wr_o <= 1'b0;
      reg_addr_o <= ~a;
      reg_wdata_o <= ~d;
      #1;
   endtask : wr

   task automatic rd(input logic [7:0] a, output logic [7:0] d);
      @(posedge sys_clk_i);
      reg_addr_o <= a;
      reg_rd_o <= 1'b1;
      @(posedge sys_clk_i);
      reg_rd_o <= 1'b0;
      reg_addr_o <= ~a;
      #1;
      d = reg_rdata_i;
   endtask : rd

   // Servicing the watchdog is a plain value write
   task automatic svc(input logic [7:0] n);
      wr(wct_pkg::ADDR_VAL, n);
   endtask : svc
endmodule : wct_host
`default_nettype wire

// ---- dv/test_watchdog_countdown_timer.sv ----
`timescale 1ns/1ps
`default_nettype none
module test_watchdog_countdown_timer;
   localparam int bdiv = 4;
   localparam int p64 = bdiv * wct_pkg::DIV_64HZ;
   localparam logic [7:0] a_ctl = wct_pkg::ADDR_CTL;
   localparam logic [7:0] a_val = wct_pkg::ADDR_VAL;
   localparam logic [7:0] a_st = wct_pkg::ADDR_STATUS;
   logic clk = 1'b0;
   logic rst = 1'b1;
   logic minute_second_flag = 1'b0;
   logic cden = 1'b0;
   logic [7:0] addr, wdata, rdata, d;
   logic wr, rd, irq_n, rst_n;
   logic [31:0] seed = 32'h6ba17ee5;
   int bad_count = 0;
   int check_count = 0;
   int t, n;

   initial begin
      forever #2 clk = ~clk;
   end

   wct_top #(.BASE_DIV(bdiv), .CNT_W(8)) i_dut (.sys_clk_i(clk),
      .rst_i(rst), .reg_addr_i(addr), .reg_wr_i(wr), .reg_rd_i(rd),
      .reg_wdata_i(wdata), .reg_rdata_o(rdata),
      .minute_second_flag_i(minute_second_flag), .countdown_irq_enable_i(cden),
      .irq_n_o(irq_n), .rst_n_o(rst_n));
   wct_host host (.sys_clk_i(clk), .reg_addr_o(addr), .reg_wr_o(wr),
      .reg_rd_o(rd), .reg_wdata_o(wdata), .reg_rdata_i(rdata));

   // ==========================================
   // Helpers
   function automatic logic [31:0] xs(input logic [31:0] s);
      s = s ^ (s << 13);
      s = s ^ (s >> 17);
      s = s ^ (s << 5);
      return s;
   endfunction : xs

   task automatic chk(input logic [7:0] got, input int e, input string m);
      check_count++;
      if (got !== e[7:0]) begin
         bad_count++;
         $display("mismatch %0t %s got %h exp %h", $time, m, got, e[7:0]);
      end
   endtask : chk

   task automatic win(input int c, input int lo, input int hi);
      check_count++;
      if (c < lo || c > hi) begin
         bad_count++;
         $display("mismatch %0t span %0d not in %0d..%0d", $time, c, lo, hi);
      end
   endtask : win

   // Edges until the picked output reaches lvl, bounded by lim
   task automatic wait_lvl(input bit sel, input logic lvl, input int lim,
                           output int c);
      c = 0;
      while (((sel ? rst_n : irq_n) !== lvl) && c < lim) begin
         @(posedge clk);
         #1;
         c++;
      end
   endtask : wait_lvl

   task automatic pins(input int e, input string m);
      chk({6'h00, irq_n, rst_n}, e, m);
   endtask : pins

   task automatic conclude();
      if (bad_count == 0 && check_count > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask : conclude

   // ==========================================
   // Scenarios
   initial begin
      repeat (16) @(posedge clk);
      rst <= 1'b0;
      host.rd(a_ctl, d);
      chk(d, 8'h03, "ctl reset");
      pins(3, "idle");
      host.rd(8'h20, d);
      chk(d, 8'h00, "unmapped");
      host.wr(a_val, 8'h00);
      for (int k = 0; k < 8; k++) begin
         seed = xs(seed);
         host.wr(a_ctl, seed[7:0]);
         host.rd(a_ctl, d);
         chk(d, seed[7:0] & 8'he3, "ctl readback");
      end
      pins(3, "stopped");
      seed = xs(seed);
      host.wr(a_ctl, 8'h03);
      host.wr(a_val, seed[7:0]);
      host.rd(a_val, d);
      chk(d, seed[7:0], "value held");
      // Watchdog in both modes, status read clears, no reload
      for (int k = 0; k < 2; k++) begin
         seed = xs(seed);
         n = 1 + seed[2:0];
         host.wr(a_val, 8'h00);
         host.wr(a_ctl, k ? 8'hc0 : 8'h80);
         host.wr(a_val, n[7:0]);
         wait_lvl(k, 1'b0, n * bdiv + 10, t);
         win(t, (n - 1) * bdiv, n * bdiv + 4);
         pins(k ? 2 : 1, "output select");
         host.wr(a_st, 8'h00);
         host.rd(a_st, d);
         chk(d & 8'h40, 8'h40, "flag kept");
         repeat (12 * bdiv) @(posedge clk);
         #1;
         pins(3, "no reload");
      end
      host.svc(8'h02);
      wait_lvl(1, 1'b0, 20, t);
      win(t, bdiv, 2 * bdiv + 4);
      host.svc(8'h03);
      repeat (2) @(posedge clk);
      #1;
      pins(3, "serviced");
      wait_lvl(1, 1'b0, 30, t);
      win(t + 2, 2 * bdiv, 3 * bdiv + 4);
      host.wr(a_val, 8'h00);
      repeat (2) @(posedge clk);
      #1;
      pins(3, "zero load");
      repeat (40) @(posedge clk);
      #1;
      pins(3, "zero stops");
      host.wr(a_ctl, 8'h81);
      host.wr(a_val, 8'h02);
      wait_lvl(0, 1'b0, 2 * p64 + 10, t);
      win(t, p64, 2 * p64 + 4);
      // Countdown, level then disabled then pulse
      host.wr(a_val, 8'h00);
      @(posedge clk);
      cden <= 1'b1;
      host.wr(a_ctl, 8'h40);
      host.wr(a_val, 8'h03);
      wait_lvl(0, 1'b0, 30, t);
      win(t, 2 * bdiv, 3 * bdiv + 4);
      host.rd(a_st, d);
      chk(d & 8'h08, 8'h08, "cd flag");
      pins(1, "level");
      host.rd(a_val, d);
      win(d, 1, 3);
      host.wr(a_st, 8'h00);
      repeat (2) @(posedge clk);
      #1;
      pins(3, "flag cleared");
      wait_lvl(0, 1'b0, 30, t);
      win(t, 0, 3 * bdiv + 4);
      @(posedge clk);
      cden <= 1'b0;
      host.wr(a_st, 8'h00);
      repeat (8 * bdiv) @(posedge clk);
      #1;
      pins(3, "irq disabled");
      host.rd(a_st, d);
      chk(d & 8'h08, 8'h08, "cd runs");
      @(posedge clk);
      cden <= 1'b1;
      host.wr(a_ctl, 8'h60);
      host.wr(a_st, 8'h00);
      wait_lvl(0, 1'b0, 30, t);
      wait_lvl(0, 1'b1, 30, t);
      win(t, 1, bdiv + 3);
      host.wr(a_ctl, 8'h00);
      host.wr(a_st, 8'h00);
      @(posedge clk);
      minute_second_flag <= 1'b1;
      repeat (3) @(posedge clk);
      #1;
      pins(1, "msf level");
      host.rd(a_st, d);
      chk(d & 8'h80, 8'h80, "msf seen");
      @(posedge clk);
      minute_second_flag <= 1'b0;
      repeat (3) @(posedge clk);
      #1;
      pins(3, "msf gone");
      conclude();
   end

   initial begin
      #200000;
      bad_count++;
      conclude();
   end
endmodule : test_watchdog_countdown_timer
`default_nettype wire
